// File: frcct_top.sv
// Contract
// R1 - compare a match pulses irq a, no clear
// R2 - capture a triggers from either selected pin
// R3 - valid edge copies count into register a
// R4 - compare b match pulses irq b, no clear
// R5 - capture b triggers only from pin a
// R6 - present count readable at all times
// R7 - edge select rising, falling, both; ignore others
`timescale 1ns/1ps
`default_nettype none
module frcct_top
  import frcct_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // count enable
  input wire logic count_en_i,
  // capture pins
  input wire logic capture_pin_a_i,
  input wire logic capture_pin_b_i,
  // configuration
  input wire logic mode_capture_a_i,
  input wire logic mode_capture_b_i,
  input wire logic trig_sel_a_i,
  input wire logic [1:0] edge_sel_pin_a_i,
  input wire logic [1:0] edge_sel_pin_b_i,
  // compare values written by software
  input wire logic cmp_wr_a_i,
  input wire logic cmp_wr_b_i,
  input wire logic [frcct_pkg::CNT_W-1:0] cmp_data_i,
  // counter and register readback
  output logic [frcct_pkg::CNT_W-1:0] free_running_count_o,
  output logic [frcct_pkg::CNT_W-1:0] capcomp_reg_a_o,
  output logic [frcct_pkg::CNT_W-1:0] capcomp_reg_b_o,
  // match interrupts
  output logic match_irq_a_o,
  output logic match_irq_b_o
);
  import frcct_pkg::*;
  // state
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cc_a_reg;
  logic [CNT_W-1:0] cc_b_reg;
  logic irq_a_reg;
  logic irq_b_reg;
  // valid edges from both pins
  logic edge_a_w;
  logic edge_b_w;
  // pin a detector
  frcct_edge_det u_det_a (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(capture_pin_a_i),
    .edge_sel_i(edge_sel_pin_a_i),
    .edge_o(edge_a_w)
  );
  // pin b detector
  frcct_edge_det u_det_b (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(capture_pin_b_i),
    .edge_sel_i(edge_sel_pin_b_i),
    .edge_o(edge_b_w)
  );
  // trigger selection for register a [R2]
  wire trig_a_w = (trig_sel_a_i == TRIG_PIN_B) ? edge_b_w : edge_a_w;
  // register b only ever uses pin a [R5]
  wire trig_b_w = edge_a_w;
  // capture strobes
  wire cap_a_w = mode_capture_a_i & trig_a_w;
  wire cap_b_w = mode_capture_b_i & trig_b_w;
  // compare matches on the running count
  wire match_a_w = ~mode_capture_a_i & (cnt_reg == cc_a_reg);
  wire match_b_w = ~mode_capture_b_i & (cnt_reg == cc_b_reg);
  // next counter, never cleared by a match [R1] [R4]
  wire [CNT_W-1:0] cnt_next = count_en_i ? cnt_reg + 16'h0001 : cnt_reg;
  // free-running counter
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // register a: capture or software write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cc_a_reg <= CC_RST;
    end else if (cap_a_w) begin
      cc_a_reg <= cnt_reg; // [R3]
    end else if (cmp_wr_a_i && !mode_capture_a_i) begin
      cc_a_reg <= cmp_data_i;
    end
  end
  // register b: capture or software write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cc_b_reg <= CC_RST;
    end else if (cap_b_w) begin
      cc_b_reg <= cnt_reg; // [R5]
    end else if (cmp_wr_b_i && !mode_capture_b_i) begin
      cc_b_reg <= cmp_data_i;
    end
  end
  // match pulses, one per counter step at the matching value
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= match_a_w & count_en_i; // [R1]
      irq_b_reg <= match_b_w & count_en_i; // [R4]
    end
  end
  // outputs straight from flip-flops
  assign free_running_count_o = cnt_reg; // [R6]
  assign capcomp_reg_a_o = cc_a_reg;
  assign capcomp_reg_b_o = cc_b_reg;
  assign match_irq_a_o = irq_a_reg;
  assign match_irq_b_o = irq_b_reg;
endmodule // frcct_top
`default_nettype wire

// File: frcct_pkg.sv
package frcct_pkg;
  // counter and register width
  localparam int unsigned CNT_W = 16;
  // reset value of counter and capture/compare registers
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CC_RST = 16'h0000;
  // valid edge encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // trigger select for register a
  localparam logic TRIG_PIN_A = 1'b0;
  localparam logic TRIG_PIN_B = 1'b1;
endpackage : frcct_pkg

// File: frcct_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
// valid edge detector for one capture input
module frcct_edge_det
  import frcct_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // pin and edge selection
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  // detected valid edge
  output logic edge_o
);
  // previous pin level
  logic prev_reg;
  // raw edges
  wire rise_w = pin_i & ~prev_reg;
  wire fall_w = ~pin_i & prev_reg;
  // only the selected edges count [R7]
  assign edge_o = (rise_w & edge_sel_i[0]) | (fall_w & edge_sel_i[1]);
  // remember last level
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_i;
    end
  end
endmodule // frcct_edge_det
`default_nettype wire

// File: frcct_pins.sv
`timescale 1ns/1ps
`default_nettype none
// capture pin source; levels move on falling edges only
module frcct_pins (
  input wire logic ref_clk_i,
  input wire logic [1:0] lvl_i,
  output logic pin_a_o,
  output logic pin_b_o
);
  always_ff @(negedge ref_clk_i) {pin_b_o, pin_a_o} <= lvl_i;
endmodule // frcct_pins
`default_nettype wire

// File: frcct_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module frcct_asserts
  import frcct_pkg::*;
(
  // clock, reset, inputs
  input wire logic ref_clk_i, rst_n_i, count_en_i, capture_pin_a_i, trig_sel_a_i,
  input wire logic mode_capture_a_i, mode_capture_b_i,
  input wire logic [1:0] edge_sel_pin_a_i,
  // outputs
  input wire logic [15:0] free_running_count_o, capcomp_reg_a_o, capcomp_reg_b_o,
  input wire logic match_irq_a_o, match_irq_b_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic [15:0] c = free_running_count_o, a = capcomp_reg_a_o, b = capcomp_reg_b_o;
  wire logic ma = mode_capture_a_i, mb = mode_capture_b_i, p = capture_pin_a_i;
  wire logic t = trig_sel_a_i == TRIG_PIN_A, en = count_en_i;
  a_count_step: assert property (en |=> c == 16'($past(c) + 1)) else $error("step");
  a_match_a: assert property (!ma && en && c == a |=> match_irq_a_o) else $error("irq a");
  a_match_b: assert property (!mb && en && c == b |=> match_irq_b_o) else $error("irq b");
  a_no_clear: assert property (match_irq_a_o || match_irq_b_o |-> c == 16'($past(c) + 1))
    else $error("clear");
  a_capture_a: assert property (ma && t && edge_sel_pin_a_i[0] && $rose(p) |=> a == $past(c))
    else $error("cap a");
  a_capture_b: assert property (mb && edge_sel_pin_a_i[1] && $fell(p) |=> b == $past(c))
    else $error("cap b");
  a_edge_skip: assert property (ma && t && edge_sel_pin_a_i == EDGE_RISE && $fell(p) |=> $stable(a))
    else $error("edge");
endmodule // frcct_asserts
bind frcct_top frcct_asserts chk_u (.*);
`default_nettype wire

// File: free_running_capture_compare_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module free_running_capture_compare_timer_test;
  import frcct_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, ma = 0, mb = 0, ts = 0, w = 0, qa = 0, qb = 0, pa, pb;
  logic ia = 0, ib = 0, ira, irb;
  logic [1:0] lvl = 0, sa = 0, sb = 0;
  logic [15:0] d = 0, xc = 0, xa = 0, xb = 0, c, ra, rb;
  int errors = 0, check_count = 0;
  always #5 clk = ~clk;
  frcct_pins src (.ref_clk_i(clk), .lvl_i(lvl), .pin_a_o(pa), .pin_b_o(pb));
  frcct_top uut (.ref_clk_i(clk), .rst_n_i(rst_n), .count_en_i(en), .capture_pin_a_i(pa),
    .capture_pin_b_i(pb), .mode_capture_a_i(ma), .mode_capture_b_i(mb), .trig_sel_a_i(ts),
    .edge_sel_pin_a_i(sa), .edge_sel_pin_b_i(sb), .cmp_wr_a_i(w), .cmp_wr_b_i(w), .cmp_data_i(d),
    .free_running_count_o(c), .capcomp_reg_a_o(ra), .capcomp_reg_b_o(rb), .match_irq_a_o(ira),
    .match_irq_b_o(irb));
  // valid edge of one pin under its edge select
  function automatic logic hit(logic [1:0] s, logic p, logic n);
    return (s[0] & ~p & n) | (s[1] & p & ~n);
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s %h %h", n, e, s);
    end
  endtask
  task automatic results;
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hCFF6C610));
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int k = 0; k < 8; k++) begin
      // modes, trigger and edges from the pass number; writes asked at pass start, then random
      {ma, mb, ts, w, d} = {k[0], k[1], k[2], 1'b1, 16'(xc + 16'h0005)};
      {sa, sb} = {2'(k % 4), 2'(3 - k % 4)};
      repeat (20) begin
        @(posedge clk);
        // match pulse due from the values standing before this edge
        {ia, ib} = {~ma & en & (xc == xa), ~mb & en & (xc == xb)};
        if (!ma && w) xa = d;
        if (!mb && w) xb = d;
        if (ma && hit(ts ? sb : sa, ts ? qb : qa, ts ? pb : pa)) xa = xc;
        if (mb && hit(sa, qa, pa)) xb = xc;
        {qb, qa, xc, lvl} = {pb, pa, 16'(xc + en), 2'($urandom)};
        @(negedge clk) {en, w} = 2'($urandom);
        chk("irq a", 16'(ia), 16'(ira));
        chk("irq b", 16'(ib), 16'(irb));
      end
      chk("reg a", xa, ra);
      chk("reg b", xb, rb);
      chk("count", xc, c);
    end
    results;
  end
  // hang guard
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule // free_running_capture_compare_timer_test
`default_nettype wire
